/* File: rtl/set_features_subcommand_handler.sv */
// Feature-setting subcommand handler: decodes one subcommand and keeps the feature state.
// Assumes the dispatcher presents subcommand and sector count on the same clock as a
// one-cycle strobe, and that the flush engine answers on this clock too.
`timescale 1ns/100ps
module set_features_subcommand_handler #(
  parameter logic [2:0] MAX_PIO = 3'h4,
  parameter logic [2:0] MAX_MULTIWORD = 3'h2,
  parameter logic [2:0] MAX_ULTRA = 3'h6,
  parameter logic IORDY_CAN_DISABLE = 1'b1,
  parameter logic [7:0] MIN_CURRENT = 8'h10,
  parameter logic [7:0] MAX_CURRENT = 8'h7D
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic softReset,
  input wire logic cmdValid,
  input wire logic [7:0] featureCode,
  input wire logic [7:0] sectorCount,
  output logic cmdReady,
  output logic cmdDone,
  output logic cmdAbort,
  output logic [7:0] cylLowOut,
  output logic [7:0] cylHighOut,
  output logic flushReq,
  input wire logic flushDone,
  input wire logic dataRegAccess,
  output logic io16Active,
  output logic byteMode,
  output logic cacheOn,
  output logic [2:0] pioMode,
  output logic iordyOn,
  output logic dmaUltra,
  output logic [2:0] dmaMode,
  output logic apmOn,
  output logic [7:0] apmLevel,
  output logic extPowerOn,
  output logic power1On,
  output logic aheadOn,
  output logic longExtra4,
  output logic [7:0] currentLimit,
  output logic restoreOnSoft
);
  import set_features_pkg::*;

  // Command sequencing states.
  typedef enum logic {IDLE, FLUSH} phase_type;

  // Whole state of the block.
  typedef struct packed {
    phase_type phase;
    logic done;
    logic abort;
    logic [7:0] cylLow;
    logic [7:0] cylHigh;
    logic byteMode;
    logic cache;
    logic [2:0] pio;
    logic iordyOff;
    logic ultra;
    logic [2:0] dma;
    logic apm;
    logic [7:0] apmLevel;
    logic extPower;
    logic power1;
    logic ahead;
    logic long4;
    logic [7:0] current;
    logic restore;
  } state_type;

  state_type cur_ff; // Registered state.
  state_type nxt_cur; // Next state.

  // Clamps a requested current to the supported range.
  function automatic logic [7:0] clampCurrent(input logic [7:0] req);
    if (req < MIN_CURRENT) begin
      return MIN_CURRENT;
    end else if (req > MAX_CURRENT) begin
      return MAX_CURRENT;
    end
    return req;
  endfunction : clampCurrent

  // Loads every feature setting with its power-on value.
  function automatic state_type withDefaults(input state_type s);
    state_type r;
    r = s;
    r.byteMode = 1'b0;
    r.cache = RST_CACHE;
    r.pio = RST_PIO_MODE;
    r.iordyOff = 1'b0;
    r.ultra = RST_DMA_ULTRA;
    r.dma = RST_DMA_MODE;
    r.apm = 1'b0;
    r.apmLevel = RST_APM_LEVEL;
    r.extPower = 1'b0;
    r.power1 = RST_PWR1;
    r.ahead = RST_AHEAD;
    r.long4 = RST_LONG_EXTRA;
    r.current = MAX_CURRENT;
    r.restore = RST_RESTORE;
    return r;
  endfunction : withDefaults

  logic [4:0] xferType; // Transfer type field of the count.
  logic [2:0] xferMode; // Mode number field of the count.
  assign xferType = sectorCount[TYPE_MSB:TYPE_LSB];
  assign xferMode = sectorCount[MODE_MSB:0];

  // Decodes the subcommand and computes the next state.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.abort = 1'b0;
    // Soft reset returns the settings to power-on values only when enabled.
    if (softReset && cur_ff.restore) begin
      nxt_cur = withDefaults(nxt_cur);
    end
    unique case (cur_ff.phase)
      IDLE: begin
        if (cmdValid) begin
          nxt_cur.done = 1'b1;
          unique case (featureCode)
            SUB_BYTE_MODE_ON: nxt_cur.byteMode = 1'b1;
            SUB_BYTE_MODE_OFF: nxt_cur.byteMode = 1'b0;
            SUB_CACHE_ON: nxt_cur.cache = 1'b1;
            SUB_CACHE_OFF: begin
              // Completion waits until the cache has been written back.
              nxt_cur.cache = 1'b0;
              nxt_cur.done = 1'b0;
              nxt_cur.phase = FLUSH;
            end
            SUB_XFER_MODE: begin
              // One register per mode class keeps exactly one mode selected.
              if (xferType == TYPE_PIO_DEFAULT && xferMode == MODE_DEFAULT) begin
                nxt_cur.pio = RST_PIO_MODE;
                nxt_cur.iordyOff = 1'b0;
              end else if (xferType == TYPE_PIO_DEFAULT && xferMode == MODE_NO_IORDY) begin
                nxt_cur.pio = RST_PIO_MODE;
                nxt_cur.iordyOff = IORDY_CAN_DISABLE;
              end else if (xferType == TYPE_PIO_FLOW && xferMode <= MAX_PIO) begin
                nxt_cur.pio = xferMode;
                nxt_cur.iordyOff = 1'b0;
              end else if (xferType == TYPE_MULTIWORD && xferMode <= MAX_MULTIWORD) begin
                nxt_cur.ultra = 1'b0;
                nxt_cur.dma = xferMode;
              end else if (xferType == TYPE_ULTRA && xferMode <= MAX_ULTRA) begin
                nxt_cur.ultra = 1'b1;
                nxt_cur.dma = xferMode;
              end else begin
                nxt_cur.abort = 1'b1;
              end
            end
            SUB_APM_ON: begin
              // Level is stored; nothing in the block acts on it.
              if (sectorCount == APM_RESERVED_LOW || sectorCount == APM_RESERVED_HIGH) begin
                nxt_cur.abort = 1'b1;
              end else begin
                nxt_cur.apm = 1'b1;
                nxt_cur.apmLevel = sectorCount;
              end
            end
            SUB_APM_OFF: nxt_cur.apm = 1'b0;
            SUB_EXTPWR_ON: nxt_cur.extPower = 1'b1;
            SUB_EXTPWR_OFF: nxt_cur.extPower = 1'b0;
            SUB_PWR1_ON: nxt_cur.power1 = 1'b1;
            SUB_PWR1_OFF: nxt_cur.power1 = 1'b0;
            SUB_AHEAD_OFF: nxt_cur.ahead = 1'b0;
            SUB_AHEAD_ON: nxt_cur.ahead = 1'b1;
            SUB_LONG_EXTRA: nxt_cur.long4 = 1'b1;
            SUB_KEEP_ON_SOFT: nxt_cur.restore = 1'b0;
            SUB_RESTORE_ON_SOFT: nxt_cur.restore = 1'b1;
            SUB_NOP_A, SUB_NOP_B, SUB_NOP_C: begin
              // Accepted without any change of state.
              nxt_cur.done = 1'b1;
            end
            SUB_CURRENT: begin
              nxt_cur.current = clampCurrent(sectorCount);
              nxt_cur.cylLow = MIN_CURRENT;
              nxt_cur.cylHigh = MAX_CURRENT;
            end
            default: nxt_cur.abort = 1'b1;
          endcase
        end
      end
      FLUSH: begin
        // Completion is reported in the cycle after the flush engine finishes.
        if (flushDone) begin
          nxt_cur.done = 1'b1;
          nxt_cur.phase = IDLE;
        end
      end
    endcase
  end

  // Registers the whole state.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{phase: IDLE, done: 1'b0, abort: 1'b0, cylLow: RST_BYTE, cylHigh: RST_BYTE,
                  byteMode: 1'b0, cache: RST_CACHE, pio: RST_PIO_MODE, iordyOff: 1'b0,
                  ultra: RST_DMA_ULTRA, dma: RST_DMA_MODE, apm: 1'b0, apmLevel: RST_APM_LEVEL,
                  extPower: 1'b0, power1: RST_PWR1, ahead: RST_AHEAD, long4: RST_LONG_EXTRA,
                  current: MAX_CURRENT, restore: RST_RESTORE};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Drives the outputs from the registered state, io16Active together with dataRegAccess.
  assign cmdReady = (cur_ff.phase == IDLE);
  assign cmdDone = cur_ff.done;
  assign cmdAbort = cur_ff.abort;
  assign cylLowOut = cur_ff.cylLow;
  assign cylHighOut = cur_ff.cylHigh;
  assign flushReq = (cur_ff.phase == FLUSH);
  assign io16Active = dataRegAccess && !cur_ff.byteMode;
  assign byteMode = cur_ff.byteMode;
  assign cacheOn = cur_ff.cache;
  assign pioMode = cur_ff.pio;
  assign iordyOn = !cur_ff.iordyOff || (cur_ff.pio >= PIO_IORDY_NEEDED);
  assign dmaUltra = cur_ff.ultra;
  assign dmaMode = cur_ff.dma;
  assign apmOn = cur_ff.apm;
  assign apmLevel = cur_ff.apmLevel;
  assign extPowerOn = cur_ff.extPower;
  assign power1On = cur_ff.power1;
  assign aheadOn = cur_ff.ahead;
  assign longExtra4 = cur_ff.long4;
  assign currentLimit = cur_ff.current;
  assign restoreOnSoft = cur_ff.restore;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // A command taken while idle without a soft reset.
  sequence cmdTaken(logic [7:0] code);
    cmdReady && cmdValid && !softReset && featureCode == code;
  endsequence

  a_byte_mode_set: assert property (cmdTaken(SUB_BYTE_MODE_ON) |=> byteMode && cmdDone)
    else $error("byte mode not entered");
  a_io16_byte_off: assert property (byteMode && dataRegAccess |-> !io16Active)
    else $error("16-bit indication during byte mode");
  // Clean completion pulse; it drops after one cycle unless a new command was taken then.
  sequence doneOnce;
    cmdDone && !cmdAbort ##1 (!cmdDone || $past(cmdValid));
  endsequence

  // Cache disable holds completion back until the flush engine has answered.
  a_flush_before_done: assert property (
    cmdTaken(SUB_CACHE_OFF) |=> !cmdDone && flushReq && !cacheOn)
    else $error("cache disable completed without flush");
  a_flush_finish: assert property (flushReq && flushDone |=> doneOnce)
    else $error("flush completion not reported once");
  // Command decoding and transfer-mode selection.
  a_unknown_abort: assert property (cmdTaken(8'h00) |=> cmdDone && cmdAbort)
    else $error("unknown subcommand not aborted");
  a_iordy_high_pio: assert property (pioMode >= PIO_IORDY_NEEDED |-> iordyOn)
    else $error("IORDY off in high PIO mode");
  a_ultra_excludes: assert property (
    cmdTaken(SUB_XFER_MODE) && xferType == TYPE_ULTRA && xferMode <= MAX_ULTRA
    |=> dmaUltra && dmaMode == $past(xferMode))
    else $error("ultra selection not taken");
  // Power management level and current limit.
  a_apm_reserved: assert property (
    cmdTaken(SUB_APM_ON) && sectorCount == APM_RESERVED_HIGH
    |=> cmdAbort && $stable(apmLevel))
    else $error("reserved power level accepted");
  a_current_range: assert property (
    currentLimit >= MIN_CURRENT && currentLimit <= MAX_CURRENT)
    else $error("current limit outside range");
  a_current_report: assert property (
    cmdTaken(SUB_CURRENT) |=> cylLowOut == MIN_CURRENT && cylHighOut == MAX_CURRENT)
    else $error("current range not reported");
  // Soft reset keeps or restores the settings; a command in the same cycle is left out.
  a_soft_keep: assert property (
    softReset && !restoreOnSoft && !cmdValid |=> $stable(currentLimit) && $stable(pioMode))
    else $error("settings lost on soft reset");
  a_soft_restore: assert property (
    softReset && restoreOnSoft && !cmdValid |=> aheadOn && !power1On && restoreOnSoft)
    else $error("defaults not restored on soft reset");
endmodule : set_features_subcommand_handler

/* File: common/set_features_pkg.sv */
// Package for the feature-setting subcommand handler.
// Assumes a single clock domain and a command dispatcher that hands over one subcommand at a time.
package set_features_pkg;
  // Subcommand codes carried in the feature byte.
  localparam logic [7:0] SUB_BYTE_MODE_ON = 8'h01;
  localparam logic [7:0] SUB_BYTE_MODE_OFF = 8'h81;
  localparam logic [7:0] SUB_CACHE_ON = 8'h02;
  localparam logic [7:0] SUB_CACHE_OFF = 8'h82;
  localparam logic [7:0] SUB_XFER_MODE = 8'h03;
  localparam logic [7:0] SUB_APM_ON = 8'h05;
  localparam logic [7:0] SUB_APM_OFF = 8'h85;
  localparam logic [7:0] SUB_EXTPWR_ON = 8'h09;
  localparam logic [7:0] SUB_EXTPWR_OFF = 8'h89;
  localparam logic [7:0] SUB_PWR1_ON = 8'h0A;
  localparam logic [7:0] SUB_PWR1_OFF = 8'h8A;
  localparam logic [7:0] SUB_AHEAD_OFF = 8'h55;
  localparam logic [7:0] SUB_AHEAD_ON = 8'hAA;
  localparam logic [7:0] SUB_KEEP_ON_SOFT = 8'h66;
  localparam logic [7:0] SUB_RESTORE_ON_SOFT = 8'hCC;
  localparam logic [7:0] SUB_NOP_A = 8'h69;
  localparam logic [7:0] SUB_NOP_B = 8'h96;
  localparam logic [7:0] SUB_NOP_C = 8'h97;
  localparam logic [7:0] SUB_CURRENT = 8'h9A;
  localparam logic [7:0] SUB_LONG_EXTRA = 8'hBB;
  // Transfer-type field of the sector count byte, bits 7:3.
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 3;
  localparam int MODE_MSB = 2;
  localparam logic [4:0] TYPE_PIO_DEFAULT = 5'h00;
  localparam logic [4:0] TYPE_PIO_FLOW = 5'h01;
  localparam logic [4:0] TYPE_MULTIWORD = 5'h04;
  localparam logic [4:0] TYPE_ULTRA = 5'h08;
  localparam logic [2:0] MODE_DEFAULT = 3'h0;
  localparam logic [2:0] MODE_NO_IORDY = 3'h1;
  localparam logic [2:0] PIO_IORDY_NEEDED = 3'h3;
  // Power management level limits.
  localparam logic [7:0] APM_RESERVED_LOW = 8'h00;
  localparam logic [7:0] APM_RESERVED_HIGH = 8'hFF;
  // Power-on values of the feature settings.
  localparam logic [2:0] RST_PIO_MODE = 3'h0;
  localparam logic [2:0] RST_DMA_MODE = 3'h0;
  localparam logic RST_DMA_ULTRA = 1'b0;
  localparam logic RST_CACHE = 1'b1;
  localparam logic RST_AHEAD = 1'b1;
  localparam logic RST_LONG_EXTRA = 1'b1;
  localparam logic RST_RESTORE = 1'b1;
  localparam logic RST_PWR1 = 1'b0;
  localparam logic [7:0] RST_APM_LEVEL = 8'hFE;
  localparam logic [7:0] RST_BYTE = 8'h00;
endpackage : set_features_pkg

/* File: tb/host_model.sv */
// Host model: writes feature code and count, and stands in for the flush engine.
// Assumes the handler samples everything on ref_clk.
`timescale 1ns/100ps
module host_model (
  input wire logic ref_clk,
  input wire logic cmdReady,
  input wire logic cmdDone,
  input wire logic cmdAbort,
  input wire logic flushReq,
  output logic cmdValid,
  output logic [7:0] featureCode,
  output logic [7:0] sectorCount,
  output logic flushDone
);
  int flushDelay = 3; // Edges the flush engine stalls.
  int fcnt = 0; // Edges seen with a flush pending.
  int flushLen = 0; // Length of the last flush, in edges.
  initial begin
    cmdValid = 1'h0;
    featureCode = 8'h00;
    sectorCount = 8'h00;
    flushDone = 1'h0;
  end
  // Flush engine: answers with a one-cycle pulse after a stall.
  always @(posedge ref_clk) begin
    if (flushReq === 1'h1) begin
      fcnt <= fcnt + 1;
      flushDone <= (fcnt == flushDelay);
    end else begin
      if (fcnt != 0) flushLen <= fcnt;
      fcnt <= 0;
      flushDone <= 1'h0;
    end
  end
  // One command: hold until taken, then wait for the done pulse.
  task automatic issue(input logic [7:0] code, input logic [7:0] cnt, output logic ab);
    int n;
    ab = 1'hX;
    @(posedge ref_clk);
    cmdValid <= 1'h1;
    featureCode <= code;
    sectorCount <= cnt;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (cmdReady === 1'h1) break;
    end
    // Released lines show the inverse so a stale value never matches.
    cmdValid <= 1'h0;
    featureCode <= ~code;
    sectorCount <= ~cnt;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (cmdDone === 1'h1) begin
        ab = cmdAbort;
        break;
      end
    end
  endtask : issue
endmodule : host_model

/* File: tb/set_features_subcommand_handler_test.sv */
// Self-checking bench for the feature-setting subcommand handler.
// Assumes host_model drives the command side.
`timescale 1ns/100ps
module set_features_subcommand_handler_test;
  import set_features_pkg::*;
  localparam logic [7:0] LO_CUR = 8'h10; // Lowest current reported.
  localparam logic [7:0] HI_CUR = 8'h7D; // Highest current reported.
  logic ref_clk, rst, softReset, dataRegAccess, cmdValid, cmdReady, cmdDone, cmdAbort;
  logic flushReq, flushDone, io16Active, byteMode, cacheOn, iordyOn, dmaUltra, apmOn;
  logic extPowerOn, power1On, aheadOn, longExtra4, restoreOnSoft;
  logic [7:0] featureCode, sectorCount, cylLowOut, cylHighOut, apmLevel, currentLimit;
  logic [2:0] pioMode, dmaMode;
  int failures = 0; // Mismatches seen.
  int nTests = 0; // Comparisons made.
  // Handler with its capability limits spelled out.
  set_features_subcommand_handler #(.MAX_PIO(3'h4), .MAX_MULTIWORD(3'h2), .MAX_ULTRA(3'h6),
    .IORDY_CAN_DISABLE(1'h1), .MIN_CURRENT(LO_CUR), .MAX_CURRENT(HI_CUR)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .softReset(softReset), .cmdValid(cmdValid),
    .featureCode(featureCode), .sectorCount(sectorCount), .cmdReady(cmdReady),
    .cmdDone(cmdDone), .cmdAbort(cmdAbort), .cylLowOut(cylLowOut), .cylHighOut(cylHighOut),
    .flushReq(flushReq), .flushDone(flushDone), .dataRegAccess(dataRegAccess),
    .io16Active(io16Active), .byteMode(byteMode), .cacheOn(cacheOn), .pioMode(pioMode),
    .iordyOn(iordyOn), .dmaUltra(dmaUltra), .dmaMode(dmaMode), .apmOn(apmOn),
    .apmLevel(apmLevel), .extPowerOn(extPowerOn), .power1On(power1On), .aheadOn(aheadOn),
    .longExtra4(longExtra4), .currentLimit(currentLimit), .restoreOnSoft(restoreOnSoft));
  // Host side of the command interface.
  host_model i_host (.ref_clk(ref_clk), .cmdReady(cmdReady), .cmdDone(cmdDone),
    .cmdAbort(cmdAbort), .flushReq(flushReq), .cmdValid(cmdValid),
    .featureCode(featureCode), .sectorCount(sectorCount), .flushDone(flushDone));
  // Compares one bit.
  task automatic cb(input string nm, input logic e, input logic g);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cb
  // Compares one byte.
  task automatic cw(input string nm, input logic [7:0] e, input logic [7:0] g);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cw
  // Sends a command and checks its abort status.
  task automatic send(input logic [7:0] c, input logic [7:0] n, input logic ea);
    logic ab;
    i_host.issue(c, n, ab);
    cb("abort", ea, ab);
  endtask : send
  // Transfer-mode command with the expected mode state after it.
  task automatic tm(input logic [7:0] n, input logic ea, input logic [2:0] p,
      input logic io, input logic u, input logic [2:0] d);
    send(SUB_XFER_MODE, n, ea);
    cw("pio", {5'h00, p}, {5'h00, pioMode});
    cb("iordy", io, iordyOn);
    cb("ultra", u, dmaUltra);
    cw("dma", {5'h00, d}, {5'h00, dmaMode});
  endtask : tm
  // Power-on values, byte mode and the 16-bit indication.
  task automatic t_basic();
    cb("ahead", 1'h1, aheadOn);
    cb("long", 1'h1, longExtra4);
    cb("pwr1", 1'h0, power1On);
    cb("restore", 1'h1, restoreOnSoft);
    cw("limit", HI_CUR, currentLimit);
    cw("cylLow", 8'h00, cylLowOut);
    cw("cylHigh", 8'h00, cylHighOut);
    send(SUB_BYTE_MODE_ON, 8'h00, 1'h0);
    cb("byte", 1'h1, byteMode);
    @(posedge ref_clk) dataRegAccess <= 1'h1;
    @(posedge ref_clk);
    cb("io16", 1'h0, io16Active);
    send(SUB_BYTE_MODE_OFF, 8'h00, 1'h0);
    cb("byte", 1'h0, byteMode);
    cb("io16", 1'h1, io16Active);
    dataRegAccess <= 1'h0;
  endtask : t_basic
  // Cache off must wait for a stalled flush.
  task automatic t_cache();
    i_host.flushDelay = 5;
    send(SUB_CACHE_OFF, 8'h00, 1'h0);
    cb("ready", 1'h1, cmdReady);
    cb("flushReq", 1'h0, flushReq);
    @(posedge ref_clk);
    cw("flush", 8'h07, i_host.flushLen[7:0]);
    cb("cache", 1'h0, cacheOn);
    send(SUB_CACHE_ON, 8'h00, 1'h0);
    cb("cache", 1'h1, cacheOn);
  endtask : t_cache
  // Every transfer type, limits and the DMA exclusion.
  task automatic t_xfer();
    tm(8'h0C, 1'h0, 3'h4, 1'h1, 1'h0, 3'h0);
    tm(8'h0D, 1'h1, 3'h4, 1'h1, 1'h0, 3'h0);
    tm(8'h22, 1'h0, 3'h4, 1'h1, 1'h0, 3'h2);
    tm(8'h46, 1'h0, 3'h4, 1'h1, 1'h1, 3'h6);
    tm(8'h23, 1'h1, 3'h4, 1'h1, 1'h1, 3'h6);
    tm(8'h21, 1'h0, 3'h4, 1'h1, 1'h0, 3'h1);
    tm(8'h10, 1'h1, 3'h4, 1'h1, 1'h0, 3'h1);
    tm(8'h01, 1'h0, 3'h0, 1'h0, 1'h0, 3'h1);
    tm(8'h00, 1'h0, 3'h0, 1'h1, 1'h0, 3'h1);
    tm(8'h0B, 1'h0, 3'h3, 1'h1, 1'h0, 3'h1);
  endtask : t_xfer
  // Power management levels and current limit.
  task automatic t_power();
    send(SUB_APM_ON, 8'h80, 1'h0);
    cb("apm", 1'h1, apmOn);
    send(SUB_APM_ON, APM_RESERVED_LOW, 1'h1);
    send(SUB_APM_ON, APM_RESERVED_HIGH, 1'h1);
    cw("level", 8'h80, apmLevel);
    send(SUB_APM_OFF, 8'h00, 1'h0);
    cb("apm", 1'h0, apmOn);
    send(SUB_CURRENT, 8'h06, 1'h0);
    cw("limit", LO_CUR, currentLimit);
    cw("cylLow", LO_CUR, cylLowOut);
    cw("cylHigh", HI_CUR, cylHighOut);
    send(SUB_CURRENT, 8'hFF, 1'h0);
    cw("limit", HI_CUR, currentLimit);
    send(SUB_CURRENT, 8'h20, 1'h0);
    cw("limit", 8'h20, currentLimit);
  endtask : t_power
  // Single-bit features, no-ops and two unknown codes.
  task automatic t_misc();
    send(SUB_PWR1_ON, 8'h00, 1'h0);
    cb("pwr1", 1'h1, power1On);
    send(SUB_PWR1_OFF, 8'h00, 1'h0);
    cb("pwr1", 1'h0, power1On);
    send(SUB_PWR1_ON, 8'h00, 1'h0);
    cb("pwr1", 1'h1, power1On);
    send(SUB_EXTPWR_ON, 8'h00, 1'h0);
    cb("extpwr", 1'h1, extPowerOn);
    send(SUB_EXTPWR_OFF, 8'h00, 1'h0);
    cb("extpwr", 1'h0, extPowerOn);
    send(SUB_AHEAD_OFF, 8'h00, 1'h0);
    cb("ahead", 1'h0, aheadOn);
    send(SUB_AHEAD_ON, 8'h00, 1'h0);
    cb("ahead", 1'h1, aheadOn);
    send(SUB_LONG_EXTRA, 8'h00, 1'h0);
    cb("long", 1'h1, longExtra4);
    send(SUB_NOP_A, 8'h00, 1'h0);
    send(SUB_NOP_B, 8'h00, 1'h0);
    send(SUB_NOP_C, 8'h00, 1'h0);
    cw("limit", 8'h20, currentLimit);
    send(8'h42, 8'h00, 1'h1);
    send(8'h00, 8'h00, 1'h1);
  endtask : t_misc
  // Soft reset keeps settings, then restores them once re-enabled.
  task automatic t_soft();
    send(SUB_AHEAD_OFF, 8'h00, 1'h0);
    send(SUB_KEEP_ON_SOFT, 8'h00, 1'h0);
    // The first pass keeps the settings, the second restores them.
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk) softReset <= 1'h1;
      @(posedge ref_clk) softReset <= 1'h0;
      @(posedge ref_clk);
      cb("ahead", k[0], aheadOn);
      cw("limit", k[0] ? HI_CUR : 8'h20, currentLimit);
      cb("pwr1", !k[0], power1On);
      cw("pio", k[0] ? 8'h00 : 8'h03, {5'h00, pioMode});
      send(SUB_RESTORE_ON_SOFT, 8'h00, 1'h0);
    end
    cw("pio", 8'h00, {5'h00, pioMode});
  endtask : t_soft
  // Verdict and end of the run.
  task automatic report_and_stop();
    if (failures == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // Clock at 125 MHz.
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Watchdog well beyond the expected run.
  initial begin
    #160000;
    failures++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    rst = 1'h1;
    softReset = 1'h0;
    dataRegAccess = 1'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    t_basic();
    t_cache();
    t_xfer();
    t_power();
    t_misc();
    t_soft();
    report_and_stop();
  end
endmodule : set_features_subcommand_handler_test
